/* include/mbg_pkg.sv */
// constants and state types for the misc backlight, irq and pin block
package mbg_pkg;
	// register port geometry
	localparam int ADDR_W = 24;
	localparam int DATA_W = 32;

	// byte addresses of the registers
	localparam logic [23:0] OFS_PIN_DIR = 24'h10248C;
	localparam logic [23:0] OFS_PIN_VAL = 24'h102490;
	localparam logic [23:0] OFS_IRQ_FLAGS = 24'h102498;
	localparam logic [23:0] OFS_IRQ_GEN = 24'h10249C;
	localparam logic [23:0] OFS_IRQ_MASK = 24'h1024A0;
	localparam logic [23:0] OFS_IRQ_CLEAR = 24'h1024FC;
	localparam logic [23:0] OFS_BL_FREQ = 24'h1024C0;
	localparam logic [23:0] OFS_BL_DUTY = 24'h1024C4;

	// field widths and positions
	localparam int IRQ_N = 8;
	localparam int PIN_N = 8;
	localparam int FREQ_W = 14;
	localparam int DUTY_W = 8;
	localparam int GEN_BIT = 0;
	localparam int DRV_LO = 2;
	localparam int DRV_HI = 6;
	localparam int DRV_W = 5;
	localparam logic [7:0] VALUE_PINS = 8'h83;

	// reset values
	localparam logic [7:0] RST_PIN_DIR = 8'h80;
	localparam logic [7:0] RST_PIN_VAL = 8'h00;
	localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
	localparam logic RST_IRQ_GEN = 1'b0;
	localparam logic [7:0] RST_IRQ_MASK = 8'hFF;
	localparam logic [13:0] RST_BL_FREQ = 14'h00FA;
	localparam logic [7:0] RST_BL_DUTY = 8'h80;

	// timing: clock period and derived rate
	localparam int CLK_PERIOD_NS = 50;
	localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
	localparam int STEP_W = 7;
	localparam int ACC_W = 25;
	localparam logic [6:0] STEP_LAST = 7'h7F;

	// register bank state
	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] val;
		logic [7:0] flags;
		logic gen;
		logic [7:0] mask;
		logic [13:0] freq;
		logic [7:0] duty;
		logic [31:0] rdata;
		logic irq;
	} mbg_regs_t;

	// backlight generator state
	typedef struct packed {
		logic [24:0] acc;
		logic [6:0] step;
		logic [7:0] duty;
		logic [13:0] freq;
		logic out;
	} mbg_pwm_t;
endpackage

/* src/mbg_pwm.sv */
// backlight pwm generator with period-boundary update
`timescale 1ns/10ps
module mbg_pwm #(
	parameter int CLK_HZ = mbg_pkg::CLK_HZ
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [13:0] freq_req,
	input wire logic [7:0] duty_req,
	output logic pwm_out,
	output logic period_start
);
	localparam logic [24:0] MOD = 25'(CLK_HZ);

	mbg_pkg::mbg_pwm_t s_r;
	mbg_pkg::mbg_pwm_t s_nxt;
	logic [24:0] inc;
	logic [24:0] sum;

	// 128 steps per period: step rate is freq*128, so period is 1/freq
	always_comb begin
		s_nxt = s_r;
		inc = 25'({s_r.freq, 7'h00});
		sum = s_r.acc + inc;
		period_start = 1'b0;
		if (sum >= MOD) begin
			s_nxt.acc = sum - MOD;
			s_nxt.step = s_r.step + 7'h01;
			// new settings only at the wrap, so no runt pulse
			if (s_r.step == mbg_pkg::STEP_LAST) begin
				s_nxt.duty = duty_req;
				s_nxt.freq = freq_req;
				period_start = 1'b1;
			end
		end else begin
			s_nxt.acc = sum;
		end
		// zero never high, 128 or more always high
		s_nxt.out = ({1'b0, s_r.step} < s_r.duty);
	end

	// state register; reset settings give 250 Hz at full duty
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s_r <= '{acc: 25'h0000000, step: 7'h00,
				duty: mbg_pkg::RST_BL_DUTY,
				freq: mbg_pkg::RST_BL_FREQ, out: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pwm_out = s_r.out;
endmodule

/* src/mbg_pins.sv */
// general purpose pin drivers and readback
`timescale 1ns/10ps
module mbg_pins #(
	parameter int PIN_N = mbg_pkg::PIN_N
) (
	input wire logic [7:0] dir,
	input wire logic [7:0] val,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output logic [7:0] pin_rd
);
	// per pin: only pins 0, 1 and 7 carry a value bit
	for (genvar i = 0; i < PIN_N; i++) begin : g_pin
		localparam logic HAS_VAL = mbg_pkg::VALUE_PINS[i];
		assign pin_oe[i] = dir[i];
		assign pin_out[i] = HAS_VAL & val[i];
		// inputs read the pin, outputs and drive bits the register
		assign pin_rd[i] = (HAS_VAL && !dir[i]) ? pin_in[i] : val[i];
	end
endmodule

/* src/mbg_regs.sv */
// misc register bank: backlight, interrupt flags and pin control
`timescale 1ns/10ps
// Contract
// - duty is low byte, 0 to 128
// - duty 0 off, 128 full on
// - frequency field bits 13:0 in hertz
// - reset frequency gives 250 Hz
// - mask bit one lets source through
// - mask resets to all ones
// - global enable bit zero gates interrupt
// - event sets its pending flag
// - reading flags returns then clears them
// - flags reset to zero
// - value bits 0, 1, 7 drive pins
// - value bits 2 to 6 set drive
// - direction bit one makes pin output
// - only pin seven output after reset
module mbg_regs #(
	parameter int CLK_HZ = mbg_pkg::CLK_HZ
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [23:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [31:0] reg_rdata,
	input wire logic [7:0] irq_event,
	output logic irq_out,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output logic [4:0] pin_drive,
	output logic backlight_pwm,
	output logic backlight_period
);
	mbg_pkg::mbg_regs_t s_r;
	mbg_pkg::mbg_regs_t s_nxt;

	// address decode hits, one per register
	logic hit_dir;
	logic hit_val;
	logic hit_flags;
	logic hit_gen;
	logic hit_mask;
	logic hit_clear;
	logic hit_freq;
	logic hit_duty;
	logic hit_any;

	// qualified write strobes
	logic wr_dir;
	logic wr_val;
	logic wr_gen;
	logic wr_mask;
	logic wr_clear;
	logic wr_freq;
	logic wr_duty;

	// qualified read strobes
	logic rd_flags;
	logic rd_any;

	// flag bookkeeping
	logic [7:0] flag_clr;
	logic [7:0] flag_set;
	logic [7:0] flag_kept;
	logic [7:0] flag_live;

	// read data path
	logic [31:0] rd_word;
	logic [7:0] pin_rd;

	// interrupt path
	logic [7:0] irq_gated;
	logic irq_any;

	// decode: full-width compare so aliases cannot hit
	always_comb begin
		hit_dir = (reg_addr == mbg_pkg::OFS_PIN_DIR);
		hit_val = (reg_addr == mbg_pkg::OFS_PIN_VAL);
		hit_flags = (reg_addr == mbg_pkg::OFS_IRQ_FLAGS);
		hit_gen = (reg_addr == mbg_pkg::OFS_IRQ_GEN);
		hit_mask = (reg_addr == mbg_pkg::OFS_IRQ_MASK);
		hit_clear = (reg_addr == mbg_pkg::OFS_IRQ_CLEAR);
		hit_freq = (reg_addr == mbg_pkg::OFS_BL_FREQ);
		hit_duty = (reg_addr == mbg_pkg::OFS_BL_DUTY);
		hit_any = hit_dir | hit_val | hit_flags | hit_gen;
		hit_any = hit_any | hit_mask | hit_clear | hit_freq | hit_duty;
	end

	// write strobes; the flags register has no write path
	always_comb begin
		wr_dir = reg_we & hit_dir;
		wr_val = reg_we & hit_val;
		wr_gen = reg_we & hit_gen;
		wr_mask = reg_we & hit_mask;
		wr_clear = reg_we & hit_clear;
		wr_freq = reg_we & hit_freq;
		wr_duty = reg_we & hit_duty;
	end

	// read strobes
	always_comb begin
		rd_flags = reg_re & hit_flags;
		rd_any = reg_re & hit_any;
	end

	// flag clear sources: read of flags or write to clear register
	always_comb begin
		flag_clr = 8'h00;
		if (rd_flags) begin
			flag_clr = 8'hFF;
		end
		if (wr_clear) begin
			flag_clr = flag_clr | reg_wdata[7:0];
		end
	end

	// events this cycle always survive a clear in the same cycle
	always_comb begin
		flag_set = irq_event;
		flag_kept = s_r.flags & ~flag_clr;
		flag_live = flag_kept | flag_set;
	end

	// read mux; unmapped and write-only addresses read as zero
	always_comb begin
		rd_word = 32'h00000000;
		unique case (1'b1)
			hit_dir: begin
				rd_word[7:0] = s_r.dir;
			end
			hit_val: begin
				rd_word[7:0] = pin_rd;
			end
			hit_flags: begin
				// value seen is the one before the clear
				rd_word[7:0] = s_r.flags;
			end
			hit_gen: begin
				rd_word[mbg_pkg::GEN_BIT] = s_r.gen;
			end
			hit_mask: begin
				rd_word[7:0] = s_r.mask;
			end
			hit_freq: begin
				rd_word[13:0] = s_r.freq;
			end
			hit_duty: begin
				rd_word[7:0] = s_r.duty;
			end
			hit_clear: begin
				rd_word = 32'h00000000;
			end
			default: begin
				rd_word = 32'h00000000;
			end
		endcase
	end

	// gate each pending flag by the mask it will sit beside;
	// taken from the strobe, not s_nxt, to keep the logic acyclic
	always_comb begin
		irq_gated = flag_live & (wr_mask ? reg_wdata[7:0] : s_r.mask);
		irq_any = |irq_gated;
	end

	// next-state assembly for the whole bank
	always_comb begin
		s_nxt = s_r;

		// pin direction: bit n steers pin n
		if (wr_dir) begin
			s_nxt.dir = reg_wdata[7:0];
		end

		// pin values and drive strength share one byte
		if (wr_val) begin
			s_nxt.val = reg_wdata[7:0];
		end

		// pending flags: no software write, only set and clear
		s_nxt.flags = flag_live;

		// global enable keeps only bit zero
		if (wr_gen) begin
			s_nxt.gen = reg_wdata[mbg_pkg::GEN_BIT];
		end

		// per-source mask
		if (wr_mask) begin
			s_nxt.mask = reg_wdata[7:0];
		end

		// frequency is stored as written; the generator samples it
		// at its next period boundary
		if (wr_freq) begin
			s_nxt.freq = reg_wdata[13:0];
		end

		// duty above 128 is stored but behaves as full on
		if (wr_duty) begin
			s_nxt.duty = reg_wdata[7:0];
		end

		// read data valid only in the cycle after the read strobe
		if (rd_any) begin
			s_nxt.rdata = rd_word;
		end else begin
			s_nxt.rdata = 32'h00000000;
		end

		// registered irq follows the state it will sit beside
		s_nxt.irq = s_nxt.gen & irq_any;
	end

	// one register for the whole bank
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s_r.dir <= mbg_pkg::RST_PIN_DIR;
			s_r.val <= mbg_pkg::RST_PIN_VAL;
			s_r.flags <= mbg_pkg::RST_IRQ_FLAGS;
			s_r.gen <= mbg_pkg::RST_IRQ_GEN;
			s_r.mask <= mbg_pkg::RST_IRQ_MASK;
			s_r.freq <= mbg_pkg::RST_BL_FREQ;
			s_r.duty <= mbg_pkg::RST_BL_DUTY;
			s_r.rdata <= 32'h00000000;
			s_r.irq <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the bank
	assign reg_rdata = s_r.rdata;
	assign irq_out = s_r.irq;

	// drive strength field passed to the pad ring
	assign pin_drive = s_r.val[mbg_pkg::DRV_HI:mbg_pkg::DRV_LO];

	// pin drivers; the pad ring resolves the wire from pin_oe
	mbg_pins #(
		.PIN_N(mbg_pkg::PIN_N)
	) u_pins (
		.dir(s_r.dir),
		.val(s_r.val),
		.pin_in(pin_in),
		.pin_out(pin_out),
		.pin_oe(pin_oe),
		.pin_rd(pin_rd)
	);

	// backlight generator; a zero frequency simply freezes it,
	// which software avoids by keeping to the supported span
	mbg_pwm #(
		.CLK_HZ(CLK_HZ)
	) u_pwm (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.freq_req(s_r.freq),
		.duty_req(s_r.duty),
		.pwm_out(backlight_pwm),
		.period_start(backlight_period)
	);
endmodule

/* dv/mbg_regs_props.sv */
// port-level checks for the misc register bank
`timescale 1ns/10ps
module mbg_chk #(
	parameter int CLK_HZ = 20000000
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [23:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	input wire logic [31:0] reg_rdata,
	input wire logic [7:0] irq_event,
	input wire logic irq_out,
	input wire logic [7:0] pin_in,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [4:0] pin_drive,
	input wire logic backlight_pwm,
	input wire logic backlight_period
);
	// one domain, so clock and reset are given once
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	wire logic [23:0] a = reg_addr;

	AST_OE: assert property (reg_we && a == mbg_pkg::OFS_PIN_DIR
		|=> pin_oe == $past(reg_wdata[7:0])) else $error("oe bad");
	AST_VAL: assert property (reg_we && a == mbg_pkg::OFS_PIN_VAL
		|=> pin_out == ($past(reg_wdata[7:0]) & 8'h83)
		&& pin_drive == $past(reg_wdata[6:2])) else $error("pin bad");
	AST_RES: assert property (reg_re |=> reg_rdata[31:14] == 18'h0)
		else $error("reserved bits set");
	AST_RDIR: assert property (reg_re && a == mbg_pkg::OFS_PIN_DIR
		|=> reg_rdata == {24'h0, pin_oe}) else $error("dir read bad");
	AST_FCLR: assert property (reg_re && a == mbg_pkg::OFS_IRQ_FLAGS
		&& irq_event == 8'h00 |=> !irq_out) else $error("flags kept");
	AST_GEN: assert property (reg_we && a == mbg_pkg::OFS_IRQ_GEN
		&& !reg_wdata[0] |=> !irq_out) else $error("irq while off");
	AST_MASK: assert property (reg_we && a == mbg_pkg::OFS_IRQ_MASK
		&& reg_wdata[7:0] == 8'h00 |=> !irq_out) else $error("masked irq");
	AST_RISE: assert property ($rose(irq_out)
		|-> $past(irq_event) != 8'h00 || $past(reg_we))
		else $error("irq without cause");
	// a period is at least 128 cycles, so the pulse never repeats soon
	AST_PER: assert property (backlight_period
		|=> !backlight_period [*8]) else $error("period pulse long");
	cover property ($rose(irq_out));
	cover property (reg_re && a == mbg_pkg::OFS_IRQ_FLAGS);
	cover property (backlight_period && backlight_pwm);
endmodule

/* dv/mbg_regs_test.sv */
// self-checking bench for the misc register bank
`timescale 1ns/10ps
module mbg_regs_test;
	localparam int HZ = 128000; // small modulus keeps periods short
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic [23:0] reg_addr = 24'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_we = 1'b0;
	logic reg_re = 1'b0;
	logic [7:0] irq_event = 8'h00;
	logic [7:0] pin_in = 8'h00;
	logic [31:0] reg_rdata, r;
	logic [7:0] pin_out, pin_oe;
	logic [4:0] pin_drive;
	logic irq_out, backlight_pwm, backlight_period;
	int mismatches = 0;
	int n_tests = 0;
	int seed = 32'hd08d;
	int i, k, len, hi;

	mbg_regs #(.CLK_HZ(HZ)) dut (.clk_sys, .nrst, .reg_addr, .reg_wdata,
		.reg_we, .reg_re, .reg_rdata, .irq_event, .irq_out, .pin_in,
		.pin_out, .pin_oe, .pin_drive, .backlight_pwm, .backlight_period);

	// clock, 50 ns period
	initial forever #25 clk_sys = ~clk_sys;

	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask
	// one-cycle strobes, launched right after an edge
	task automatic wr(logic [23:0] a, logic [31:0] w);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= w;
		reg_we <= 1'b1;
		@(posedge clk_sys);
		reg_we <= 1'b0;
	endtask
	task automatic rd(logic [23:0] a, logic [31:0] e, string s);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk_sys);
		reg_re <= 1'b0;
		@(negedge clk_sys);
		chk(s, e, reg_rdata);
	endtask
	task automatic ev(logic [7:0] e);
		@(posedge clk_sys);
		irq_event <= e;
		@(posedge clk_sys);
		irq_event <= 8'h00;
		@(negedge clk_sys);
	endtask
	// bounded wait for the next period boundary
	task automatic per;
		k = 0;
		@(negedge clk_sys);
		while (backlight_period !== 1'b1 && k < 3000) begin
			@(negedge clk_sys);
			k++;
		end
		chk("wait", 32'h0, k >= 3000);
	endtask
	// new settings land at a boundary; measure the next whole period
	task automatic pwm(int du, int fr);
		wr(mbg_pkg::OFS_BL_FREQ, fr);
		wr(mbg_pkg::OFS_BL_DUTY, du);
		// a boundary may fall between the two writes: skip past it
		per();
		per();
		per();
		len = 0;
		hi = 0;
		while (len < 3000) begin
			hi += (backlight_pwm === 1'b1);
			len++;
			@(negedge clk_sys);
			if (backlight_period === 1'b1) break;
		end
		chk("len", HZ / fr, len);
		chk("high", du * len / 128, hi);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// watchdog, far beyond the few thousand cycles needed
	initial begin
		repeat (40000) @(posedge clk_sys);
		mismatches++;
		end_sim();
	end

	initial begin
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		chk("oe0", 32'h80, pin_oe);
		rd(mbg_pkg::OFS_PIN_DIR, 32'h80, "dir");
		rd(mbg_pkg::OFS_PIN_VAL, 32'h0, "val");
		rd(mbg_pkg::OFS_IRQ_FLAGS, 32'h0, "flags");
		rd(mbg_pkg::OFS_IRQ_GEN, 32'h0, "gen");
		rd(mbg_pkg::OFS_IRQ_MASK, 32'hFF, "mask");
		rd(mbg_pkg::OFS_BL_FREQ, 32'hFA, "freq");
		rd(mbg_pkg::OFS_BL_DUTY, 32'h80, "duty");
		rd(24'h1024B0, 32'h0, "hole");
		// random direction, value and pin levels; inputs read back
		for (i = 0; i < 8; i++) begin
			r = $random(seed);
			@(posedge clk_sys);
			pin_in <= r[23:16];
			wr(mbg_pkg::OFS_PIN_DIR, r[7:0]);
			wr(mbg_pkg::OFS_PIN_VAL, r[15:8]);
			@(negedge clk_sys);
			chk("oe", r[7:0], pin_oe);
			chk("out", r[15:8] & 8'h83, pin_out);
			chk("drv", r[14:10], pin_drive);
			rd(mbg_pkg::OFS_PIN_VAL, (r[15:8] & 8'h7C) | (((r[7:0] & r[15:8])
				| (~r[7:0] & r[23:16])) & 8'h83), "rb");
		end
		// each source alone, then the same source masked
		wr(mbg_pkg::OFS_IRQ_GEN, 32'h1);
		for (i = 0; i < 8; i++) begin
			ev(8'h01 << i);
			chk("irq", 32'h1, irq_out);
			rd(mbg_pkg::OFS_IRQ_FLAGS, 32'h1 << i, "flag");
			chk("irq0", 32'h0, irq_out);
			rd(mbg_pkg::OFS_IRQ_FLAGS, 32'h0, "clr");
			wr(mbg_pkg::OFS_IRQ_MASK, ~(32'h1 << i) & 32'hFF);
			ev(8'h01 << i);
			chk("mask", 32'h0, irq_out);
			rd(mbg_pkg::OFS_IRQ_FLAGS, 32'h1 << i, "mflag");
			wr(mbg_pkg::OFS_IRQ_MASK, 32'hFF);
		end
		// global enable off holds the line low with flags pending
		wr(mbg_pkg::OFS_IRQ_GEN, 32'h0);
		ev(8'hFF);
		chk("goff", 32'h0, irq_out);
		wr(mbg_pkg::OFS_IRQ_GEN, 32'h1);
		@(negedge clk_sys);
		chk("gon", 32'h1, irq_out);
		rd(mbg_pkg::OFS_IRQ_FLAGS, 32'hFF, "all");
		// partial clear goes through the clear register only
		ev(8'h0F);
		wr(mbg_pkg::OFS_IRQ_CLEAR, 32'h05);
		rd(mbg_pkg::OFS_IRQ_FLAGS, 32'h0A, "pclr");
		pwm(0, 250);
		pwm(128, 250);
		pwm(64, 500);
		pwm(37, 1000);
		end_sim();
	end
endmodule

bind mbg_regs mbg_chk #(.CLK_HZ(CLK_HZ)) props (.clk_sys, .nrst, .reg_addr,
	.reg_wdata, .reg_we, .reg_re, .reg_rdata, .irq_event, .irq_out,
	.pin_in, .pin_out, .pin_oe, .pin_drive, .backlight_pwm,
	.backlight_period);
